// [bench/rap_exec_bench.sv]
// Self-checking bench of the execute stage against a memory model.
// Assumes rap_pkg is compiled first; legacy 26-bit mode is on for one run of compares.
`timescale 1ns/10ps
module rap_exec_bench import rap_pkg::*;;
  logic clk, rstn, in_valid, in_set_flags, in_legacy_p, in_imm_sel, in_sh_by_reg, in_link;
  logic in_psr_saved, in_ls_load, in_ls_byte, in_ls_pre, in_ls_up, in_ls_wback, in_ls_trans;
  logic cfg_legacy26, mem_rvalid, slow, wr_en_q, pc_we_q, base_we_q, ld_we_q, mem_req_q;
  logic mem_we_q, mem_byte_q, mem_user_q, illegal_q, v1;
  logic [31:0] in_rn_val, in_rd_val, in_pc, in_rm_val, mem_rdata, wr_data_q, pc_target_q;
  logic [31:0] base_data_q, ld_data_q, mem_addr_q, mem_wdata_q, cur_status_q, saved_status_q;
  logic [31:0] cur_e, sav_e;
  logic [3:0] in_opcode, in_rd, in_rn, in_rot, in_field_mask, wr_idx_q, base_idx_q, ld_idx_q;
  logic [7:0] in_imm8, in_rs_val;
  logic [4:0] in_sh_imm, wr_bank_q;
  logic [2:0] in_class;
  logic [1:0] in_sh_type;
  logic [23:0] in_br_off;
  logic [11:0] in_ls_imm12;
  logic [71:0] q_wr[$], q_pc[$], q_b[$], q_mem[$], q_ld[$], q_st[$];
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  rap_exec u_rap_exec (.*);
  rap_mem_model u_rap_mem_model (.clk(clk), .rstn(rstn), .req(mem_req_q), .we(mem_we_q),
    .addr(mem_addr_q), .slow(slow), .rvalid(mem_rvalid), .rdata(mem_rdata));
  // ------
  // Checking
  // ------
  task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pop(ref logic [71:0] q[$], input string nm, input logic [71:0] s);
    if (q.size() == 0) chk(nm, ~s, s);
    else chk(nm, q.pop_front(), s);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    v1 <= in_valid;
    cyc <= cyc + 1;
    if (wr_en_q === 1'b1)
      pop(q_wr, "wr", {wr_bank_q, wr_idx_q, wr_data_q});
    if (pc_we_q === 1'b1) pop(q_pc, "pc", pc_target_q);
    if (base_we_q === 1'b1) pop(q_b, "base", {base_idx_q, base_data_q});
    if (mem_req_q === 1'b1) pop(q_mem, "mem", {mem_we_q, mem_byte_q, mem_user_q, mem_addr_q,
      mem_we_q ? mem_wdata_q : 32'h0});
    if (ld_we_q === 1'b1) pop(q_ld, "ld", {ld_idx_q, ld_data_q});
    if (v1 === 1'b1)
      pop(q_st, "st", {illegal_q, cur_status_q, saved_status_q});
    if (cyc == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ------
  // Reference model and stimulus
  // ------
  function automatic logic [32:0] sh(input logic [31:0] v, input logic [1:0] k,
    input logic [5:0] n, input logic br, input logic ci);
    logic [63:0] r;
    logic [32:0] t;
    logic [5:0] m;
    m = (!br && n == 6'h0 && k != 2'h0) ? 6'h20 : n;
    r = {v, v} >> m[4:0];
    case (k)
      2'h0: t = {ci, v} << m;
      2'h1: t = {v, ci} >> m;
      2'h2: t = $signed({v, ci}) >>> m;
      default: t = {r[31:0], r[31]};
    endcase
    if (k != 2'h0) t = {t[0], t[32:1]};
    if (k == 2'h3 && m == 6'h20) t = {v[0], ci, v[31:1]};
    if (k != 2'h0 && m == 6'h0) t = {ci, v};
    return t;
  endfunction
  function automatic logic [33:0] alu(input logic [3:0] op, input logic [31:0] a,
    input logic [31:0] b, input logic ci, input logic sc, input logic vi);
    logic [31:0] x, y;
    logic [32:0] s;
    logic k;
    x = a;
    y = (op == 4'h2 || op == 4'ha || op == 4'h6) ? ~b : b;
    k = (op == 4'h5 || op == 4'h6 || op == 4'h7) ? ci : (op == 4'h2 || op == 4'ha || op == 4'h3);
    if (op == 4'h3 || op == 4'h7) begin
      x = b;
      y = ~a;
    end
    s = x + y + k;
    case (op)
      4'h0, 4'h8: return {sc, vi, a & b};
      4'h1, 4'h9: return {sc, vi, a ^ b};
      4'hc: return {sc, vi, a | b};
      4'hd: return {sc, vi, b};
      4'he: return {sc, vi, a & ~b};
      4'hf: return {sc, vi, ~b};
      default: return {s[32], (x[31] == y[31]) && (s[31] != x[31]), s[31:0]};
    endcase
  endfunction
  task automatic rnd();
    {in_set_flags, in_legacy_p, in_imm_sel, in_sh_by_reg, in_link, in_psr_saved, in_ls_load,
      in_ls_byte, in_ls_pre, in_ls_up, in_ls_wback, in_ls_trans, slow} <= 13'($urandom);
    {in_opcode, in_rn, in_rot, in_field_mask, in_imm8, in_sh_type, in_sh_imm} <= 31'($urandom);
    {in_rn_val, in_rd_val, in_pc, in_rm_val} <= {$urandom, $urandom, $urandom, $urandom};
    in_rd <= 4'($urandom_range(13, 0));
    in_rs_val <= 8'($urandom_range(31, 0));
    {in_br_off, in_ls_imm12} <= 36'({$urandom, $urandom});
  endtask
  task automatic go(input logic [2:0] c);
    @(posedge clk);
    rnd();
    in_class <= c;
    in_valid <= 1'b1;
  endtask
  task automatic model();
    logic [63:0] r;
    logic [32:0] o;
    logic [33:0] a;
    logic [31:0] m, s, d, ad;
    logic br, u, ill;
    #1;
    br = in_sh_by_reg && in_class != 3'h4;
    u = cfg_legacy26 ? cur_e[1:0] == 2'h0 : cur_e[4:0] == 5'h10;
    ill = 1'b0;
    r = {24'h0, in_imm8, 24'h0, in_imm8} >> {in_rot, 1'b0};
    o = sh(in_rm_val, in_sh_type, br ? 6'(in_rs_val) : 6'(in_sh_imm), br, cur_e[29]);
    if (in_imm_sel && in_class != 3'h4) o = {in_rot == 4'h0 ? cur_e[29] : r[31], r[31:0]};
    m = {in_field_mask[3] ? 4'hf : 4'h0, 20'h0, in_field_mask[0] && !u ? 8'hdf : 8'h0};
    case (in_class)
      3'h0: begin
        a = alu(in_opcode, in_rn_val, o[31:0], cur_e[29], o[32], cur_e[28]);
        if (in_opcode[3:2] != 2'b10) q_wr.push_back({cur_e[4:0], in_rd, a[31:0]});
        if (cfg_legacy26 && in_legacy_p && in_opcode[3:2] == 2'b10) begin
          m = u ? 32'hf000_0000 : 32'hf000_00c3;
          cur_e = cur_e & ~m | {a[31:28], 20'h0, a[27:26], 4'h0, a[1:0]} & m;
        end else if (in_set_flags || in_opcode[3:2] == 2'b10)
          cur_e[31:28] = {a[31], a[31:0] == 32'h0, a[33:32]};
      end
      3'h1: begin
        q_pc.push_back(32'(in_pc + {{6{in_br_off[23]}}, in_br_off, 2'b00}));
        if (in_link) q_wr.push_back({cur_e[4:0], 4'he, in_pc});
      end
      3'h2: if (in_psr_saved && u) ill = 1'b1;
        else if (in_psr_saved) sav_e = sav_e & ~m | o[31:0] & m;
        else cur_e = cur_e & ~m | o[31:0] & m;
      3'h3: if (in_psr_saved && u) ill = 1'b1;
        else q_wr.push_back({cur_e[4:0], in_rd, in_psr_saved ? sav_e : cur_e});
      default: begin
        ad = in_imm_sel ? {20'h0, in_ls_imm12} : o[31:0];
        s = in_ls_up ? in_rn_val + ad : in_rn_val - ad;
        ad = in_ls_pre ? s : in_rn_val;
        d = ad ^ 32'hc3a5_96f0;
        q_mem.push_back({!in_ls_load, in_ls_byte, u || in_ls_trans && !in_ls_pre, ad,
          in_ls_load ? 32'h0 : in_ls_byte ? {4{in_rd_val[7:0]}} : in_rd_val});
        if (!in_ls_pre || in_ls_wback) q_b.push_back({in_rn, s});
        if (in_ls_load) q_ld.push_back({in_rd, in_ls_byte ? {24'h0, d[8 * ad[1:0] +: 8]} : d});
      end
    endcase
    q_st.push_back({ill, cur_e, sav_e});
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    void'($urandom(32'ha7563fcd));
    {rstn, in_valid, in_class, cfg_legacy26, v1} = 7'h0;
    cur_e = 32'h0000_00d3;
    sav_e = 32'h0;
    rnd();
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      go(3'h1);
      if (i < 2) in_br_off <= i ? 24'h7f_ffff : 24'h80_0000;
      model();
    end
    for (int i = 0; i < 48; i++) begin
      go(3'h2 + 3'(i % 2));
      {in_sh_by_reg, in_sh_imm, in_sh_type} <= 8'h0;
      if (i % 2 == 0) in_psr_saved <= !i[5];
      if (i % 2 == 0) in_field_mask <= i[5] ? {1'b1, i[3:2], 1'b0} : 4'(i[4:1]);
      model();
    end
    for (int i = 0; i < 320; i++) begin
      go(3'h0);
      in_opcode <= 4'(i);
      model();
    end
    for (int i = 0; i < 17; i++) begin
      go(3'h0);
      in_opcode <= 4'h8 + 4'(i % 4);
      in_legacy_p <= 1'b1;
      cfg_legacy26 <= i < 16;
      model();
    end
    for (int i = 0; i < 40; i++) begin
      go(3'h4);
      model();
      @(posedge clk);
      in_valid <= 1'b0;
      for (int k = 0; k < 12 && ld_we_q !== 1'b1; k++) @(posedge clk);
    end
    go(3'h2);
    {in_psr_saved, in_field_mask, in_imm_sel, in_imm8, in_rot} <= 18'h0_1900;
    model();
    for (int i = 0; i < 40; i++) begin
      go(3'(i % 4));
      in_imm_sel <= 1'b1;
      model();
    end
    @(posedge clk);
    in_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("left", 72'h0, 72'(q_wr.size() + q_pc.size() + q_b.size() + q_mem.size()
      + q_ld.size() + q_st.size()));
    end_of_test();
  end
endmodule

// [bench/rap_mem_model.sv]
// Memory port model: answers each load after a short or a long wait.
// Assumes one load outstanding and single-cycle request pulses.
`timescale 1ns/10ps
module rap_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic slow,
  // Return
  output logic rvalid,
  output logic [31:0] rdata
);
  logic [3:0] cnt_q;
  logic [31:0] a_q;
  logic [31:0] junk_q;
  // Outside a return the data lines show junk_q, which is negated each cycle from zero and so stays zero
  assign rdata = rvalid ? (a_q ^ 32'hc3a5_96f0) : junk_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      a_q <= 32'h0;
      junk_q <= 32'h0;
      rvalid <= 1'b0;
    end else begin
      junk_q <= ~junk_q + 32'h1;
      rvalid <= (cnt_q == 4'h1);
      if (req && !we) begin
        cnt_q <= slow ? 4'h6 : 4'h1;
        a_q <= addr;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// [pkg/rap_pkg.sv]
// Shared constants and types of the execute stage.
// Assumes a 32-bit core with one clock and a 16-entry register index.
package rap_pkg;
  // ----------------------------------------------------------------
  // Widths and branch reach
  // ----------------------------------------------------------------
  localparam int DW = 32;
  localparam int BR_OFF_W = 24;
  localparam int BR_REACH_BYTES = 32 * 1024 * 1024;
  localparam logic [3:0] LINK_IDX = 4'he;
  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int PSR_N = 31;
  localparam int PSR_Z = 30;
  localparam int PSR_C = 29;
  localparam int PSR_V = 28;
  localparam int LEG_I = 27;
  localparam int LEG_F = 26;
  localparam logic [31:0] PSR_FLAG_BITS = 32'hf000_0000;
  localparam logic [31:0] PSR_CTRL_BITS = 32'h0000_00df;
  localparam logic [31:0] LEG_PRIV_BITS = 32'hf000_00c3;
  localparam logic [31:0] CUR_STATUS_RST = 32'h0000_00d3;
  localparam logic [31:0] SAVED_STATUS_RST = 32'h0000_0000;
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [1:0] LEG_MODE_USER = 2'h0;
  // Field mask bit positions (flags, status, extension, control)
  localparam int FM_FLAGS = 3;
  localparam int FM_STATUS = 2;
  localparam int FM_EXT = 1;
  localparam int FM_CTRL = 0;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_AND = 4'h0, OP_EXCL_OR = 4'h1, OP_SUB = 4'h2, OP_REV_SUB = 4'h3,
    OP_ADD = 4'h4, OP_ADD_CARRY = 4'h5, OP_SUB_BORROW = 4'h6,
    OP_REV_SUB_BORROW = 4'h7, OP_TEST_MASK = 4'h8, OP_TEST_EQUIV = 4'h9,
    OP_COMPARE_SUB = 4'ha, OP_COMPARE_ADD = 4'hb, OP_INCL_OR = 4'hc,
    OP_COPY = 4'hd, OP_BIT_CLEAR = 4'he, OP_COPY_INV = 4'hf
  } rap_op_e;
  typedef enum logic [1:0] {
    SH_LEFT = 2'b00, SH_LOG_RIGHT = 2'b01, SH_ARITH_RIGHT = 2'b10,
    SH_ROT_RIGHT = 2'b11
  } rap_shift_e;
  typedef enum logic [2:0] {
    CL_DATA = 3'b000, CL_BRANCH = 3'b001, CL_STATUS_WRITE = 3'b010,
    CL_STATUS_READ = 3'b011, CL_LOAD_STORE = 3'b100
  } rap_class_e;
endpackage

// [verilog/rap_addsub.sv]
// Adder with carry in, carry out and signed overflow.
// Assumes the caller inverts an operand for subtraction.
`timescale 1ns/10ps
module rap_addsub import rap_pkg::*; (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic cin,
  // Result
  output logic [31:0] sum,
  output logic cout,
  output logic ovf
);
  // ----------------------------------------------------------------
  // Sum and flags
  // ----------------------------------------------------------------
  wire [32:0] s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
  wire c_into_top = a[31] ^ b[31] ^ s[31];
  assign sum = s[31:0];
  assign cout = s[32];
  assign ovf = c_into_top ^ s[32];
endmodule

// [verilog/rap_exec.sv]
// Execute stage: branch, data processing, status transfer, load/store.
// Assumes one decoded instruction per in_valid cycle, already condition-passed.
`timescale 1ns/10ps
module rap_exec import rap_pkg::*; #(
  parameter int OFF_W = BR_OFF_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Decode stream
  input wire logic in_valid,
  input wire logic [2:0] in_class,
  input wire logic [3:0] in_opcode,
  input wire logic in_set_flags,
  input wire logic in_legacy_p,
  input wire logic [3:0] in_rd,
  input wire logic [3:0] in_rn,
  input wire logic [31:0] in_rn_val,
  input wire logic [31:0] in_rd_val,
  input wire logic [31:0] in_pc,
  // Second operand
  input wire logic in_imm_sel,
  input wire logic [7:0] in_imm8,
  input wire logic [3:0] in_rot,
  input wire logic [31:0] in_rm_val,
  input wire logic [1:0] in_sh_type,
  input wire logic in_sh_by_reg,
  input wire logic [4:0] in_sh_imm,
  input wire logic [7:0] in_rs_val,
  // Branch
  input wire logic [OFF_W-1:0] in_br_off,
  input wire logic in_link,
  // Status transfer
  input wire logic in_psr_saved,
  input wire logic [3:0] in_field_mask,
  // Load/store
  input wire logic in_ls_load,
  input wire logic in_ls_byte,
  input wire logic in_ls_pre,
  input wire logic in_ls_up,
  input wire logic in_ls_wback,
  input wire logic in_ls_trans,
  input wire logic [11:0] in_ls_imm12,
  // Configuration
  input wire logic cfg_legacy26,
  // Memory return
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  // Register writeback
  output logic wr_en_q,
  output logic [3:0] wr_idx_q,
  output logic [31:0] wr_data_q,
  output logic [4:0] wr_bank_q,
  output logic pc_we_q,
  output logic [31:0] pc_target_q,
  output logic base_we_q,
  output logic [3:0] base_idx_q,
  output logic [31:0] base_data_q,
  output logic ld_we_q,
  output logic [3:0] ld_idx_q,
  output logic [31:0] ld_data_q,
  // Memory request
  output logic mem_req_q,
  output logic mem_we_q,
  output logic mem_byte_q,
  output logic mem_user_q,
  output logic [31:0] mem_addr_q,
  output logic [31:0] mem_wdata_q,
  // Status
  output logic [31:0] cur_status_q,
  output logic [31:0] saved_status_q,
  output logic illegal_q
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if ((1 << (OFF_W + 1)) != BR_REACH_BYTES) begin : g_chk
    $error("Branch offset width does not give the branch reach");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_user(input logic [31:0] st, input logic leg);
    is_user = leg ? (st[1:0] == LEG_MODE_USER) : (st[4:0] == MODE_USER);
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] m);
    lanes = {{8{m[FM_FLAGS]}}, {8{m[FM_STATUS]}}, {8{m[FM_EXT]}}, {8{m[FM_CTRL]}}};
  endfunction

  function automatic logic [31:0] logic_op(input rap_op_e o, input logic [31:0] a,
                                           input logic [31:0] b, input logic [31:0] s);
    case (o)
      OP_AND, OP_TEST_MASK: logic_op = a & b;
      OP_EXCL_OR, OP_TEST_EQUIV: logic_op = a ^ b;
      OP_INCL_OR: logic_op = a | b;
      OP_COPY: logic_op = b;
      OP_BIT_CLEAR: logic_op = a & ~b;
      OP_COPY_INV: logic_op = ~b;
      default: logic_op = s;
    endcase
  endfunction

  wire rap_op_e op = rap_op_e'(in_opcode);
  wire is_data = in_valid && in_class == CL_DATA;
  wire is_br = in_valid && in_class == CL_BRANCH;
  wire is_sw = in_valid && in_class == CL_STATUS_WRITE;
  wire is_sr = in_valid && in_class == CL_STATUS_READ;
  wire is_ls = in_valid && in_class == CL_LOAD_STORE;
  wire user = is_user(cur_status_q, cfg_legacy26);
  wire is_cmp = op[3:2] == 2'b10;
  wire is_logic = op inside {OP_AND, OP_EXCL_OR, OP_TEST_MASK, OP_TEST_EQUIV,
                             OP_INCL_OR, OP_COPY, OP_BIT_CLEAR, OP_COPY_INV};
  wire c_flag = cur_status_q[PSR_C];

  // ----------------------------------------------------------------
  // Second operand and index
  // ----------------------------------------------------------------
  wire imm_op = in_imm_sel && !is_ls;
  wire [31:0] sh_val = imm_op ? {24'h0, in_imm8} : in_rm_val;
  wire [1:0] sh_kind = imm_op ? SH_ROT_RIGHT : in_sh_type;
  wire [7:0] sh_amt = imm_op ? {3'h0, in_rot, 1'b0} :
                      (in_sh_by_reg && !is_ls) ? in_rs_val : {3'h0, in_sh_imm};
  wire sh_by_reg = imm_op || (in_sh_by_reg && !is_ls);
  wire [31:0] op2;
  wire sh_cout;

  rap_shifter u_shift (
    .val(sh_val),
    .kind(sh_kind),
    .amt(sh_amt),
    .by_reg(sh_by_reg),
    .cin(c_flag),
    .res(op2),
    .cout(sh_cout)
  );

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  wire rev = op == OP_REV_SUB || op == OP_REV_SUB_BORROW;
  wire sub = op inside {OP_SUB, OP_SUB_BORROW, OP_REV_SUB, OP_REV_SUB_BORROW,
                        OP_COMPARE_SUB};
  wire use_c = op inside {OP_ADD_CARRY, OP_SUB_BORROW, OP_REV_SUB_BORROW};
  wire [31:0] add_bx = rev ? in_rn_val : op2;
  wire [31:0] add_a = rev ? op2 : in_rn_val;
  wire [31:0] add_b = sub ? ~add_bx : add_bx;
  wire add_cin = use_c ? c_flag : sub;
  wire [31:0] add_sum;
  wire add_cout;
  wire add_ovf;

  rap_addsub u_alu_add (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout),
    .ovf(add_ovf)
  );

  wire [31:0] res = logic_op(op, in_rn_val, op2, add_sum);
  wire nf = res[31];
  wire zf = res == 32'h0000_0000;
  wire cf = is_logic ? sh_cout : add_cout;
  wire vf = is_logic ? cur_status_q[PSR_V] : add_ovf;

  // ----------------------------------------------------------------
  // Status word update
  // ----------------------------------------------------------------
  wire leg_p = is_data && is_cmp && in_legacy_p && cfg_legacy26;
  wire flag_upd = is_data && (in_set_flags || is_cmp) && !leg_p;
  wire [31:0] leg_val = (res & PSR_FLAG_BITS) |
                        {24'h0, res[LEG_I], res[LEG_F], 4'h0, res[1:0]};
  wire [31:0] leg_m = user ? PSR_FLAG_BITS : LEG_PRIV_BITS;
  wire [31:0] sw_allow = user ? PSR_FLAG_BITS : (PSR_FLAG_BITS | PSR_CTRL_BITS);
  wire [31:0] sw_m = lanes(in_field_mask) & sw_allow;
  wire saved_bad = (is_sw || is_sr) && in_psr_saved && user;
  wire [31:0] cur_m = flag_upd ? PSR_FLAG_BITS :
                      leg_p ? leg_m :
                      (is_sw && !in_psr_saved) ? sw_m : 32'h0;
  wire [31:0] cur_v = flag_upd ? {nf, zf, cf, vf, 28'h0} : leg_p ? leg_val : op2;
  wire [31:0] cur_d = (cur_status_q & ~cur_m) | (cur_v & cur_m);
  wire [31:0] sav_m = (is_sw && in_psr_saved && !user) ? sw_m : 32'h0;
  wire [31:0] saved_d = (saved_status_q & ~sav_m) | (op2 & sav_m);
  wire [31:0] psr_rd = (in_psr_saved ? saved_status_q : cur_status_q) &
                       (PSR_FLAG_BITS | PSR_CTRL_BITS);

  // ----------------------------------------------------------------
  // Register writeback and branch
  // ----------------------------------------------------------------
  wire wr_en_d = (is_data && !is_cmp) || (is_br && in_link) ||
                 (is_sr && !saved_bad);
  wire [3:0] wr_idx_d = is_br ? LINK_IDX : in_rd;
  wire [31:0] wr_data_d = is_br ? in_pc : is_sr ? psr_rd : res;
  wire [31:0] br_off = {{(32 - OFF_W - 2){in_br_off[OFF_W-1]}}, in_br_off, 2'b00};
  wire [31:0] br_tgt = in_pc + br_off;

  // ----------------------------------------------------------------
  // Load/store address
  // ----------------------------------------------------------------
  wire [31:0] ls_idx = in_imm_sel ? {20'h0, in_ls_imm12} : op2;
  wire [31:0] ls_sum;

  rap_addsub u_addr_add (
    .a(in_rn_val),
    .b(in_ls_up ? ls_idx : ~ls_idx),
    .cin(!in_ls_up),
    .sum(ls_sum),
    .cout(),
    .ovf()
  );

  wire [31:0] ls_addr = in_ls_pre ? ls_sum : in_rn_val;
  wire ls_wb = !in_ls_pre || in_ls_wback;
  wire ls_user = user || (in_ls_trans && !in_ls_pre);
  wire [31:0] ls_wdata = in_ls_byte ? {4{in_rd_val[7:0]}} : in_rd_val;
  logic [3:0] pend_idx_q;
  logic pend_byte_q;
  logic [1:0] pend_lane_q;
  wire [7:0] ld_byte = 8'(mem_rdata >> {pend_lane_q, 3'b000});
  wire [31:0] ld_data_d = pend_byte_q ? {24'h0, ld_byte} : mem_rdata;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_status_q <= CUR_STATUS_RST;
      saved_status_q <= SAVED_STATUS_RST;
      illegal_q <= 1'b0;
    end else begin
      cur_status_q <= cur_d;
      saved_status_q <= saved_d;
      illegal_q <= saved_bad;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_en_q <= 1'b0;
      wr_idx_q <= 4'h0;
      wr_data_q <= 32'h0;
      wr_bank_q <= 5'h00;
      pc_we_q <= 1'b0;
      pc_target_q <= 32'h0;
    end else begin
      wr_en_q <= wr_en_d;
      wr_idx_q <= wr_idx_d;
      wr_data_q <= wr_data_d;
      wr_bank_q <= cur_status_q[4:0];
      pc_we_q <= is_br;
      pc_target_q <= br_tgt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_byte_q <= 1'b0;
      mem_user_q <= 1'b0;
      mem_addr_q <= 32'h0;
      mem_wdata_q <= 32'h0;
      base_we_q <= 1'b0;
      base_idx_q <= 4'h0;
      base_data_q <= 32'h0;
    end else begin
      mem_req_q <= is_ls;
      mem_we_q <= is_ls && !in_ls_load;
      mem_byte_q <= in_ls_byte;
      mem_user_q <= ls_user;
      mem_addr_q <= ls_addr;
      mem_wdata_q <= ls_wdata;
      base_we_q <= is_ls && ls_wb;
      base_idx_q <= in_rn;
      base_data_q <= ls_sum;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_idx_q <= 4'h0;
      pend_byte_q <= 1'b0;
      pend_lane_q <= 2'h0;
      ld_we_q <= 1'b0;
      ld_idx_q <= 4'h0;
      ld_data_q <= 32'h0;
    end else begin
      if (is_ls && in_ls_load) begin
        pend_idx_q <= in_rd;
        pend_byte_q <= in_ls_byte;
        pend_lane_q <= ls_addr[1:0];
      end
      ld_we_q <= mem_rvalid;
      ld_idx_q <= pend_idx_q;
      ld_data_q <= ld_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_link;
    @(posedge clk) disable iff (!rstn)
    is_br && in_link |=> wr_en_q && wr_idx_q == LINK_IDX && wr_data_q == $past(in_pc);
  endproperty
  a_link: assert property (p_link) else $error("link not written");

  property p_copy_inv;
    @(posedge clk) disable iff (!rstn)
    is_data && op == OP_COPY_INV |=> wr_data_q == ~$past(op2);
  endproperty
  a_copy_inv: assert property (p_copy_inv) else $error("bad inverted copy");

  property p_add_carry;
    @(posedge clk) disable iff (!rstn)
    is_data && op == OP_ADD_CARRY |=>
      wr_data_q == 32'($past(in_rn_val) + $past(op2) + {31'h0, $past(c_flag)});
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("bad add with carry");

  property p_cmp_nowrite;
    @(posedge clk) disable iff (!rstn)
    is_data && is_cmp |=> !wr_en_q;
  endproperty
  a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare wrote");

  property p_user_ctrl;
    @(posedge clk) disable iff (!rstn)
    is_sw && user && !leg_p |=> cur_status_q[27:0] == $past(cur_status_q[27:0]);
  endproperty
  a_user_ctrl: assert property (p_user_ctrl) else $error("user changed control");

  property p_flags_hold;
    @(posedge clk) disable iff (!rstn)
    !flag_upd && !leg_p && !is_sw |=> $stable(cur_status_q[31:28]);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed");

  property p_logic_v;
    @(posedge clk) disable iff (!rstn)
    flag_upd && is_logic |=> cur_status_q[PSR_V] == $past(cur_status_q[PSR_V])
      && cur_status_q[PSR_C] == $past(sh_cout);
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logical flags wrong");

  property p_post_index;
    @(posedge clk) disable iff (!rstn)
    is_ls && !in_ls_pre |=> mem_req_q && base_we_q && mem_addr_q == $past(in_rn_val);
  endproperty
  a_post_index: assert property (p_post_index) else $error("bad post index");

  property p_sub_carry;
    @(posedge clk) disable iff (!rstn)
    flag_upd && op == OP_SUB |=>
      cur_status_q[PSR_C] == ($past(in_rn_val) >= $past(op2));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("bad borrow carry");

  c_link: cover property (@(posedge clk) disable iff (!rstn) is_br && in_link);
  c_leg_p: cover property (@(posedge clk) disable iff (!rstn) leg_p && !user);
  c_saved_wr: cover property (@(posedge clk) disable iff (!rstn) is_sw && in_psr_saved && !user);
  c_byte_ld: cover property (@(posedge clk) disable iff (!rstn) mem_rvalid && pend_byte_q);
endmodule

// [verilog/rap_shifter.sv]
// Barrel shifter for the second operand and the load/store index.
// Assumes amounts are already chosen by the caller; combinational only.
`timescale 1ns/10ps
module rap_shifter import rap_pkg::*; (
  // Operand
  input wire logic [31:0] val,
  input wire logic [1:0] kind,
  input wire logic [7:0] amt,
  input wire logic by_reg,
  input wire logic cin,
  // Result
  output logic [31:0] res,
  output logic cout
);
  // ----------------------------------------------------------------
  // Amount decode
  // ----------------------------------------------------------------
  wire zero_const = !by_reg && amt == 8'h00;
  wire is_rrx = zero_const && kind == SH_ROT_RIGHT;
  wire [8:0] a = (zero_const && kind != SH_LEFT) ? 9'h020 : {1'b0, amt};
  wire none = a == 9'h000;
  wire big = a > 9'h020;
  wire [63:0] t_l = {32'h0, val} << a;
  wire [63:0] t_r = {val, 32'h0} >> a;
  wire [63:0] t_a = 64'($signed({val, 32'h0}) >>> a);
  wire [5:0] r = {1'b0, a[4:0]};
  wire [31:0] t_o = (val >> r) | (val << (6'h20 - r));
  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  assign res = none ? val :
               is_rrx ? {cin, val[31:1]} :
               kind == SH_LEFT ? t_l[31:0] :
               kind == SH_LOG_RIGHT ? t_r[63:32] :
               kind == SH_ARITH_RIGHT ? t_a[63:32] : t_o;
  assign cout = none ? cin :
                is_rrx ? val[0] :
                kind == SH_LEFT ? (!big && t_l[32]) :
                kind == SH_LOG_RIGHT ? (!big && t_r[31]) :
                kind == SH_ARITH_RIGHT ? t_a[31] : t_o[31];
endmodule
